// ===== design/lsem_pkg.sv
// constants and carrier types of the load shedding energy manager
`default_nettype none
package lsem_pkg;
   localparam int NUM_LOADS = 8;
   // timing, clock of 4 ns
   localparam int CLK_PERIOD_NS = 4;
   localparam int SAMPLE_MS     = 100;
   localparam int SAMPLE_CYC    = SAMPLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SECOND_NS     = 1000000000;
   localparam int SECOND_CYC    = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [2:0] SHORE_STEP_S = 3'h1;
   localparam logic [2:0] GEN_STEP_S   = 3'h5;
   // reset values
   localparam logic [15:0] CYCLE_DELAY_RST = 16'h0078; // 120 s
   localparam logic [7:0]  GEN_RATING_RST  = 8'h78;
   localparam logic [7:0]  GEN_RATING_MAX  = 8'h78;    // 120 A
   localparam logic [7:0]  LINE_MAP_RST    = 8'h00;
   // service limits in amperes
   localparam logic [7:0] LIMIT_50A = 8'h32;
   localparam logic [7:0] LIMIT_30A = 8'h1E;
   localparam logic [7:0] LIMIT_20A = 8'h14;
   // register byte offsets
   localparam logic [7:0] ADR_GEN_RATING = 8'h00;
   localparam logic [7:0] ADR_CYC_DELAY  = 8'h04;
   localparam logic [7:0] ADR_LINE_MAP   = 8'h08;
   localparam logic [7:0] ADR_STATUS     = 8'h0C;
   localparam logic [7:0] ADR_SLOT_BASE  = 8'h20;
   localparam logic [7:0] ADR_LEARN_BASE = 8'h40;
   // field positions
   localparam int SLOT_VALID_BIT = 3;
   localparam int STAT_SVC_LSB   = 8;

   typedef enum logic [4:0] {
      SVC_NONE = 5'h01,
      SVC_GEN  = 5'h02,
      SVC_50A  = 5'h04,
      SVC_30A  = 5'h08,
      SVC_20A  = 5'h10
   } lsem_svc_type;

   typedef struct packed {
      logic       valid;
      logic [2:0] relay;
   } lsem_slot_type;

   typedef struct packed {
      logic [7:0]                         gen_rating;
      logic [15:0]                        cycle_delay;
      logic [7:0]                         line_map;
      lsem_slot_type [NUM_LOADS-1:0]      slot;
   } lsem_cfg_type;

   typedef struct packed {
      lsem_svc_type                       svc;
      logic [NUM_LOADS-1:0]               relay;
      logic [NUM_LOADS-1:0][7:0]          learned;
   } lsem_stat_type;
endpackage
`default_nettype wire

// ===== design/lsem_pacer.sv
// periodic one-cycle tick generator
`default_nettype none
module lsem_pacer #(
   parameter int unsigned PERIOD = 4 // cycles between ticks
) (
   input  wire logic clk_i,  // clock
   input  wire logic rst_i,  // synchronous reset
   output logic      tick_o  // one-cycle pulse
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;

   always_comb begin
      cnt_nxt  = cnt_r + 32'h1;
      tick_nxt = 1'b0;
      if (cnt_r >= PERIOD - 1) begin
         cnt_nxt  = 32'h0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r  <= 32'h0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;
endmodule
`default_nettype wire

// ===== design/lsem_regs.sv
// wishbone classic register file holding the configuration
`default_nettype none
module lsem_regs (
   input  wire logic                   clk_i,     // clock
   input  wire logic                   rst_i,     // synchronous reset
   input  wire logic                   wb_cyc_i,  // bus cycle
   input  wire logic                   wb_stb_i,  // strobe
   input  wire logic                   wb_we_i,   // write enable
   input  wire logic [7:0]             wb_adr_i,  // byte address
   input  wire logic [3:0]             wb_sel_i,  // byte enables
   input  wire logic [31:0]            wb_dat_i,  // write data
   output logic [31:0]                 wb_dat_o,  // read data
   output logic                        wb_ack_o,  // acknowledge
   input  wire lsem_pkg::lsem_stat_type stat_i,   // block state
   output lsem_pkg::lsem_cfg_type      cfg_o      // configuration
);
   lsem_pkg::lsem_cfg_type cfg_r;
   lsem_pkg::lsem_cfg_type cfg_nxt;
   logic [31:0]            dat_r;
   logic [31:0]            dat_nxt;
   logic                   ack_r;
   logic                   ack_nxt;
   logic                   req;
   logic [2:0]             idx;

   function automatic logic in_bank(input logic [7:0] adr, input logic [7:0] base);
      in_bank = (adr[7:5] == base[7:5]) && (adr[1:0] == 2'h0);
   endfunction

   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign idx = wb_adr_i[4:2];

   always_comb begin
      cfg_nxt = cfg_r;
      dat_nxt = 32'h0;
      ack_nxt = req;
      if (req && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            lsem_pkg::ADR_GEN_RATING: begin
               // generator rating range is 0 to 120 A
               if (wb_dat_i[7:0] > lsem_pkg::GEN_RATING_MAX) begin
                  cfg_nxt.gen_rating = lsem_pkg::GEN_RATING_MAX;
               end else begin
                  cfg_nxt.gen_rating = wb_dat_i[7:0];
               end
            end
            lsem_pkg::ADR_CYC_DELAY: cfg_nxt.cycle_delay[7:0] = wb_dat_i[7:0];
            lsem_pkg::ADR_LINE_MAP:  cfg_nxt.line_map = wb_dat_i[7:0];
            default: begin
               if (in_bank(wb_adr_i, lsem_pkg::ADR_SLOT_BASE)) begin
                  cfg_nxt.slot[idx] = wb_dat_i[3:0];
               end
            end
         endcase
      end
      if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == lsem_pkg::ADR_CYC_DELAY) begin
         cfg_nxt.cycle_delay[15:8] = wb_dat_i[15:8];
      end
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            lsem_pkg::ADR_GEN_RATING: dat_nxt = {24'h0, cfg_r.gen_rating};
            lsem_pkg::ADR_CYC_DELAY:  dat_nxt = {16'h0, cfg_r.cycle_delay};
            lsem_pkg::ADR_LINE_MAP:   dat_nxt = {24'h0, cfg_r.line_map};
            lsem_pkg::ADR_STATUS:     dat_nxt = {19'h0, stat_i.svc, stat_i.relay};
            default: begin
               if (in_bank(wb_adr_i, lsem_pkg::ADR_SLOT_BASE)) begin
                  dat_nxt = {28'h0, cfg_r.slot[idx]};
               end else if (in_bank(wb_adr_i, lsem_pkg::ADR_LEARN_BASE)) begin
                  dat_nxt = {24'h0, stat_i.learned[idx]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r.gen_rating  <= lsem_pkg::GEN_RATING_RST;
         cfg_r.cycle_delay <= lsem_pkg::CYCLE_DELAY_RST;
         cfg_r.line_map    <= lsem_pkg::LINE_MAP_RST;
         cfg_r.slot        <= '0;
         dat_r             <= 32'h0;
         ack_r             <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign cfg_o    = cfg_r;
endmodule
`default_nettype wire

// ===== design/lsem_core.sv
// load shedding energy manager: service detection, sequencing, shedding and learning
// Behaviour
// - Operate only while first or second supply line voltage is present.
// - Generator-running input marks the generator as operating for service choice.
// - Across-line voltage: report both line currents, manage each line separately.
// - Dual-line service reports generator when running, else 50 A shore.
// - Generator running: show actual current and light generator indicator.
// - Installer generator rating, 0 to 120 A, is the generator limit.
// - Generator service: loads on one by one every five seconds until rating.
// - Single line without generator: assume 30 A shore, manage energy.
// - 20 A service only by momentary user press of select switch.
// - Entering shore service: loads on in turn about one second apart.
// - Current above service rating starts switching controlled loads off.
// - First shed the load highest in the shedding table.
// - Each shed stores the measured current drop as that load's value.
// - Keep shedding in table order until below limit or all off.
// - Every shed overwrites the load's stored value with a fresh one.
// - In 50 A service shed only loads on the overloaded line.
// - Drive eight relays: five AC power, three low-voltage changeover.
// - Re-enable last shed load only when below limit with headroom enough.
// - Keep a shed load off for the cycle delay, default two minutes.
// - During delay flash indicator if current allows; then energize, steady.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`default_nettype none
module lsem_core #(
   parameter int unsigned SAMPLE_CYC = lsem_pkg::SAMPLE_CYC, // cycles per current sample
   parameter int unsigned SECOND_CYC = lsem_pkg::SECOND_CYC  // cycles per second
) (
   input  wire logic          clk_i,            // clock 250 MHz
   input  wire logic          rst_i,            // synchronous reset
   input  wire logic          line1_present_i,  // first_supply_line voltage present
   input  wire logic          line2_present_i,  // second_supply_line voltage present
   input  wire logic          cross_line_i,     // voltage across both lines
   input  wire logic          gen_run_i,        // generator running
   input  wire logic          svc_select_i,     // service select switch, high while pressed
   input  wire logic [7:0]    cur1_i,           // first line current, amperes
   input  wire logic [7:0]    cur2_i,           // second line current, amperes
   input  wire logic          wb_cyc_i,         // wishbone cycle
   input  wire logic          wb_stb_i,         // wishbone strobe
   input  wire logic          wb_we_i,          // wishbone write enable
   input  wire logic [7:0]    wb_adr_i,         // wishbone byte address
   input  wire logic [3:0]    wb_sel_i,         // wishbone byte enables
   input  wire logic [31:0]   wb_dat_i,         // wishbone write data
   output logic [31:0]        wb_dat_o,         // wishbone read data
   output logic               wb_ack_o,         // wishbone acknowledge
   output logic [7:0]         relay_o,          // relays 0-4 AC, 5-7 changeover
   output logic [7:0]         led_o,            // load status indicators
   output lsem_pkg::lsem_svc_type svc_o,        // service type to display
   output logic               dual_meter_o,     // display both line meters
   output logic               gen_led_o,        // generator service indicator
   output logic [7:0]         meter1_o,         // first line current to display
   output logic [7:0]         meter2_o,         // second line current to display
   output logic               active_o          // controller operating
);
   localparam int N = lsem_pkg::NUM_LOADS;

   typedef enum logic [3:0] {
      ST_OFF   = 4'h1,
      ST_SEQ   = 4'h2,
      ST_RUN   = 4'h4,
      ST_LEARN = 4'h8
   } lsem_state_type;

   lsem_pkg::lsem_cfg_type  cfg;
   lsem_pkg::lsem_stat_type stat;
   logic                    sample_tick;
   logic                    sec_tick;

   lsem_state_type          state_r;
   lsem_state_type          state_nxt;
   lsem_pkg::lsem_svc_type  svc_r;
   lsem_pkg::lsem_svc_type  svc_nxt;
   logic                    sel20_r;
   logic                    sel20_nxt;
   logic                    press_d_r;
   logic                    dual_r;
   logic                    active_r;
   logic [7:0]              c1_r;
   logic [7:0]              c1_nxt;
   logic [7:0]              c2_r;
   logic [7:0]              c2_nxt;
   logic [N-1:0]            relay_r;
   logic [N-1:0]            relay_nxt;
   logic [N-1:0]            led_r;
   logic [N-1:0]            led_nxt;
   logic                    blink_r;
   logic [2:0]              step_r;
   logic [2:0]              step_nxt;
   logic [8:0]              pre_r;
   logic [8:0]              pre_nxt;
   logic [2:0]              lidx_r;
   logic [2:0]              lidx_nxt;
   logic                    lline_r;
   logic                    lline_nxt;
   logic [N-1:0][7:0]       learned_r;
   logic [N-1:0][7:0]       learned_nxt;
   logic [N-1:0][15:0]      hold_r;
   logic [N-1:0][15:0]      hold_nxt;

   // derived conditions
   logic                    active;
   logic                    dual;
   logic [7:0]              limit;
   logic [1:0][8:0]         meas;
   logic [1:0]              over;
   logic                    at_limit;
   logic [N-1:0]            ctl;
   logic                    shed_ok;
   logic [2:0]              shed_idx;
   logic                    seq_ok;
   logic [2:0]              seq_idx;
   logic                    rest_ok;
   logic [2:0]              rest_idx;
   logic                    rest_fits;
   logic [8:0]              room;

   function automatic logic line_of(input logic dl, input logic [7:0] map, input logic [2:0] r);
      line_of = dl & map[r];
   endfunction

   lsem_pacer #(.PERIOD(SAMPLE_CYC)) u_sample (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (sample_tick)
   );

   lsem_pacer #(.PERIOD(SECOND_CYC)) u_second (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (sec_tick)
   );

   assign stat.svc     = svc_r;
   assign stat.relay   = relay_r;
   assign stat.learned = learned_r;

   lsem_regs u_regs (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .stat_i   (stat),
      .cfg_o    (cfg)
   );

   assign active = line1_present_i | line2_present_i;
   assign dual   = active & cross_line_i;

   // service type and limit
   always_comb begin
      sel20_nxt = sel20_r;
      if (!active || cross_line_i || gen_run_i) begin
         sel20_nxt = 1'b0;
      end else if (svc_select_i && !press_d_r) begin
         sel20_nxt = !sel20_r;
      end
      if (!active) begin
         svc_nxt = lsem_pkg::SVC_NONE;
      end else if (gen_run_i) begin
         svc_nxt = lsem_pkg::SVC_GEN;
      end else if (cross_line_i) begin
         svc_nxt = lsem_pkg::SVC_50A;
      end else if (sel20_r) begin
         svc_nxt = lsem_pkg::SVC_20A;
      end else begin
         svc_nxt = lsem_pkg::SVC_30A;
      end
      case (svc_r)
         lsem_pkg::SVC_GEN: limit = cfg.gen_rating;
         lsem_pkg::SVC_50A: limit = lsem_pkg::LIMIT_50A;
         lsem_pkg::SVC_20A: limit = lsem_pkg::LIMIT_20A;
         lsem_pkg::SVC_30A: limit = lsem_pkg::LIMIT_30A;
         default:           limit = 8'h00;
      endcase
   end

   // candidates for shedding, sequencing and restoring
   always_comb begin
      c1_nxt = sample_tick ? cur1_i : c1_r;
      c2_nxt = sample_tick ? cur2_i : c2_r;
      if (dual_r) begin
         meas[0] = {1'b0, c1_r};
         meas[1] = {1'b0, c2_r};
      end else begin
         meas[0] = {1'b0, c1_r} + {1'b0, c2_r};
         meas[1] = 9'h000;
      end
      over[0]  = meas[0] > {1'b0, limit};
      over[1]  = meas[1] > {1'b0, limit};
      at_limit = (meas[0] >= {1'b0, limit}) || (dual_r && meas[1] >= {1'b0, limit});
      ctl      = '0;
      shed_ok  = 1'b0;
      shed_idx = 3'h0;
      seq_ok   = 1'b0;
      seq_idx  = 3'h0;
      rest_ok  = 1'b0;
      rest_idx = 3'h0;
      for (int k = N - 1; k >= 0; k--) begin
         if (cfg.slot[k].valid) begin
            ctl[cfg.slot[k].relay] = 1'b1;
            // descending walk: the lowest slot wins
            if (relay_r[cfg.slot[k].relay] &&
                over[line_of(dual_r, cfg.line_map, cfg.slot[k].relay)]) begin
               shed_ok  = 1'b1;
               shed_idx = cfg.slot[k].relay;
            end
            if (!relay_r[cfg.slot[k].relay] && hold_r[cfg.slot[k].relay] == 16'h0000) begin
               seq_ok  = 1'b1;
               seq_idx = cfg.slot[k].relay;
            end
         end
      end
      for (int k = 0; k < N; k++) begin
         // ascending walk: the last shed load is the highest slot still off
         if (cfg.slot[k].valid && !relay_r[cfg.slot[k].relay] &&
             !over[line_of(dual_r, cfg.line_map, cfg.slot[k].relay)]) begin
            rest_ok  = 1'b1;
            rest_idx = cfg.slot[k].relay;
         end
      end
      room      = {1'b0, limit} - meas[line_of(dual_r, cfg.line_map, rest_idx)];
      rest_fits = rest_ok && meas[line_of(dual_r, cfg.line_map, rest_idx)] < {1'b0, limit} &&
                  room >= {1'b0, learned_r[rest_idx]};
   end

   // control sequence
   always_comb begin
      state_nxt   = state_r;
      relay_nxt   = relay_r;
      step_nxt    = step_r;
      pre_nxt     = pre_r;
      lidx_nxt    = lidx_r;
      lline_nxt   = lline_r;
      learned_nxt = learned_r;
      led_nxt     = relay_r;
      for (int i = 0; i < N; i++) begin
         hold_nxt[i] = (sec_tick && hold_r[i] != 16'h0000) ? hold_r[i] - 16'h0001 : hold_r[i];
      end
      if (!active) begin
         state_nxt = ST_OFF;
         relay_nxt = '0;
      end else if (svc_nxt != svc_r) begin
         // any change of service restarts the power-up sequence
         state_nxt = ST_SEQ;
         relay_nxt = relay_r & ~ctl;
         step_nxt  = (svc_nxt == lsem_pkg::SVC_GEN) ? lsem_pkg::GEN_STEP_S : lsem_pkg::SHORE_STEP_S;
      end else begin
         case (state_r)
            ST_OFF: begin
               state_nxt = ST_SEQ;
            end
            ST_SEQ: begin
               if (sample_tick && (over[0] || over[1])) begin
                  state_nxt = ST_RUN;
               end else if (sec_tick) begin
                  if (step_r > 3'h1) begin
                     step_nxt = step_r - 3'h1;
                  end else if (!seq_ok || (svc_r == lsem_pkg::SVC_GEN && at_limit)) begin
                     state_nxt = ST_RUN;
                  end else begin
                     relay_nxt[seq_idx] = 1'b1;
                     step_nxt = (svc_r == lsem_pkg::SVC_GEN) ? lsem_pkg::GEN_STEP_S :
                                                               lsem_pkg::SHORE_STEP_S;
                  end
               end
            end
            ST_RUN: begin
               if (sample_tick && shed_ok) begin
                  relay_nxt[shed_idx] = 1'b0;
                  hold_nxt[shed_idx]  = cfg.cycle_delay;
                  lidx_nxt            = shed_idx;
                  lline_nxt           = line_of(dual_r, cfg.line_map, shed_idx);
                  pre_nxt             = meas[line_of(dual_r, cfg.line_map, shed_idx)];
                  state_nxt           = ST_LEARN;
               end else if (rest_fits && !over[0] && !over[1]) begin
                  if (hold_r[rest_idx] != 16'h0000) begin
                     led_nxt[rest_idx] = blink_r;
                  end else if (sec_tick) begin
                     relay_nxt[rest_idx] = 1'b1;
                  end
               end
            end
            ST_LEARN: begin
               if (sample_tick) begin
                  // the first reading after the shed is the settled one
                  if (cur_line(lline_r) >= pre_r) begin
                     learned_nxt[lidx_r] = 8'h00;
                  end else if (pre_r - cur_line(lline_r) > 9'h0FF) begin
                     learned_nxt[lidx_r] = 8'hFF;
                  end else begin
                     learned_nxt[lidx_r] = 8'(pre_r - cur_line(lline_r));
                  end
                  state_nxt = ST_RUN;
               end
            end
            default: state_nxt = ST_OFF;
         endcase
      end
      if (active) begin
         relay_nxt = relay_nxt | ~ctl; // uncontrolled relays follow power
      end
   end

   // fresh sample of the learning line, taken in the tick cycle
   function automatic logic [8:0] cur_line(input logic l);
      if (dual_r) begin
         cur_line = l ? {1'b0, cur2_i} : {1'b0, cur1_i};
      end else begin
         cur_line = {1'b0, cur1_i} + {1'b0, cur2_i};
      end
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_OFF;
         svc_r     <= lsem_pkg::SVC_NONE;
         sel20_r   <= 1'b0;
         press_d_r <= 1'b0;
         dual_r    <= 1'b0;
         active_r  <= 1'b0;
         c1_r      <= 8'h00;
         c2_r      <= 8'h00;
         relay_r   <= '0;
         led_r     <= '0;
         blink_r   <= 1'b0;
         step_r    <= 3'h0;
         pre_r     <= 9'h000;
         lidx_r    <= 3'h0;
         lline_r   <= 1'b0;
         learned_r <= '0;
         hold_r    <= '0;
      end else begin
         state_r   <= state_nxt;
         svc_r     <= svc_nxt;
         sel20_r   <= sel20_nxt;
         press_d_r <= svc_select_i;
         dual_r    <= dual;
         active_r  <= active;
         c1_r      <= c1_nxt;
         c2_r      <= c2_nxt;
         relay_r   <= relay_nxt;
         led_r     <= led_nxt;
         blink_r   <= sec_tick ? !blink_r : blink_r;
         step_r    <= step_nxt;
         pre_r     <= pre_nxt;
         lidx_r    <= lidx_nxt;
         lline_r   <= lline_nxt;
         learned_r <= learned_nxt;
         hold_r    <= hold_nxt;
      end
   end

   assign relay_o      = relay_r;
   assign led_o        = led_r;
   assign svc_o        = svc_r;
   assign dual_meter_o = dual_r;
   assign gen_led_o    = (svc_r == lsem_pkg::SVC_GEN);
   assign meter1_o     = c1_r;
   assign meter2_o     = c2_r;
   assign active_o     = active_r;
endmodule
`default_nettype wire

// ===== tb/lsem_monitor.sv
// port assertions for the energy manager core
`default_nettype none
module lsem_monitor (
   input wire logic                  clk_i,           // clock
   input wire logic                  rst_i,           // reset
   input wire logic                  line1_present_i, // line 1 up
   input wire logic                  line2_present_i, // line 2 up
   input wire logic                  cross_line_i,    // across lines
   input wire logic                  gen_run_i,       // generator
   input wire logic                  wb_cyc_i,        // cycle
   input wire logic                  wb_stb_i,        // strobe
   input wire logic                  wb_ack_o,        // ack
   input wire logic [7:0]            relay_o,         // relays
   input wire lsem_pkg::lsem_svc_type svc_o,          // service
   input wire logic                  dual_meter_o,    // two meters
   input wire logic                  gen_led_o,       // gen lamp
   input wire logic                  active_o         // operating
);
   timeunit 1ns;
   timeprecision 1ps;
   wire on = line1_present_i | line2_present_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   ack_next_a: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o) else $error("no ack");
   active_track_a: assert property (1 |=> active_o == $past(on)) else $error("active wrong");
   idle_off_a: assert property (!on |=> relay_o == 8'h00 && svc_o == lsem_pkg::SVC_NONE)
      else $error("idle outputs");
   gen_svc_a: assert property (on & gen_run_i |=> svc_o == lsem_pkg::SVC_GEN) else $error("gen svc");
   dual_svc_a: assert property (line1_present_i & line2_present_i & cross_line_i & !gen_run_i
      |=> svc_o == lsem_pkg::SVC_50A) else $error("50A svc");
   shore_svc_a: assert property (on & !cross_line_i & !gen_run_i
      |=> svc_o inside {lsem_pkg::SVC_30A, lsem_pkg::SVC_20A}) else $error("shore svc");
   gen_lamp_a: assert property (on & gen_run_i |=> gen_led_o) else $error("gen lamp");
   dual_meter_a: assert property (1 |=> dual_meter_o == $past(cross_line_i & on)) else $error("meters");
endmodule
bind lsem_core lsem_monitor u_lsem_monitor (.*);
`default_nettype wire

// ===== tb/lsem_load_model.sv
// appliance loads: each energized relay draws 4 A on the first line
`default_nettype none
module lsem_load_model (
   input  wire logic [7:0] relay_i, // relay drives
   input  wire logic [7:0] extra_i, // unmanaged draw
   output logic [7:0]      cur1_o,  // first line amps
   output logic [7:0]      cur2_o   // second line amps
);
   timeunit 1ns;
   timeprecision 1ps;
   assign cur1_o = extra_i + 8'($countones(relay_i) * 4);
   assign cur2_o = 8'h00;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the energy manager core
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 50;
   logic        clk_i = 1'b0, rst_i = 1'b1, l1 = 1'b0, gen = 1'b0, sel = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, extra = 8'h00, cur1, cur2, relay, led, m1, m2;
   logic [3:0]  bsel = 4'hF;
   logic [31:0] dat = 32'h0, rdat, q;
   logic        ack, dmet, gled, act, l2 = 1'b0, xl = 1'b0;
   lsem_pkg::lsem_svc_type svc;
   int          n_errors = 0, cmp_count = 0, seed = 26651, cycles = 0, rot, k;
   logic [7:0]  exp_on;
   lsem_core #(.SAMPLE_CYC(20), .SECOND_CYC(SEC)) u_lsem_core (.clk_i(clk_i), .rst_i(rst_i),
      .line1_present_i(l1), .line2_present_i(l2), .cross_line_i(xl), .gen_run_i(gen),
      .svc_select_i(sel), .cur1_i(cur1), .cur2_i(cur2), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .relay_o(relay),
      .led_o(led), .svc_o(svc), .dual_meter_o(dmet), .gen_led_o(gled), .meter1_o(m1), .meter2_o(m2),
      .active_o(act));
   lsem_load_model u_lsem_load_model (.relay_i(relay), .extra_i(extra), .cur1_o(cur1), .cur2_o(cur2));
   initial forever #2 clk_i = ~clk_i;
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_relay(input logic [7:0] e, input int n);
      repeat (n) if (relay !== e) @(posedge clk_i);
      check("relays", relay, e);
      repeat (20) @(posedge clk_i);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, lsem_pkg::ADR_GEN_RATING, 32'h0, q);
      check("gen rating", q, 32'(lsem_pkg::GEN_RATING_RST));
      wb(1'b0, lsem_pkg::ADR_CYC_DELAY, 32'h0, q);
      check("delay", q, 32'(lsem_pkg::CYCLE_DELAY_RST));
      wb(1'b1, lsem_pkg::ADR_GEN_RATING, 32'hFF, q);
      wb(1'b0, lsem_pkg::ADR_GEN_RATING, 32'h0, q);
      check("rating clamp", q, 32'(lsem_pkg::GEN_RATING_MAX));
      wb(1'b0, 8'h80, 32'h0, q);
      check("unmapped", q, 32'h0);
      wb(1'b1, lsem_pkg::ADR_CYC_DELAY, 32'h2, q);
      rot = $random(seed) & 7;
      for (k = 0; k < 8; k++) wb(1'b1, 8'(32 + 4 * k), 32'(8 | ((k + rot) % 8)), q);
      $display("test config done");
      l1 <= 1'b1;
      repeat (3 * SEC) @(posedge clk_i);
      check("svc", svc, lsem_pkg::SVC_30A);
      check("stepping", 32'($countones(relay) inside {[2:4]}), 32'h1);
      wait_relay(8'hFF, 8 * SEC);
      exp_on = ~(8'h01 << rot);
      wait_relay(exp_on, 100);
      wb(1'b0, 8'(64 + 4 * rot), 32'h0, q);
      check("learned", q, 32'h4);
      extra <= 8'h09;
      for (k = 1; k < 3; k++) exp_on[(k + rot) % 8] = 1'b0;
      wait_relay(exp_on, 200);
      wb(1'b0, 8'(64 + 4 * ((rot + 2) % 8)), 32'h0, q);
      check("learned next", q, 32'h4);
      $display("test shedding done");
      extra <= 8'h00;
      repeat (20) @(posedge clk_i);
      check("hold off", relay, exp_on);
      check("meter", m1, 32'h14);
      wait_relay(~(8'h01 << rot), 8 * SEC);
      $display("test restore done");
      sel <= 1'b1;
      repeat (3) @(posedge clk_i);
      sel <= 1'b0;
      repeat (3) @(posedge clk_i);
      check("svc 20A", svc, lsem_pkg::SVC_20A);
      gen <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("svc gen", svc, lsem_pkg::SVC_GEN);
      check("gen lamp", gled, 1'b1);
      {gen, l2, xl} <= 3'h3;
      repeat (3) @(posedge clk_i);
      check("svc 50A", {dmet, svc}, {1'b1, lsem_pkg::SVC_50A});
      {l1, l2, xl} <= 3'h0;
      repeat (3) @(posedge clk_i);
      check("idle", {act, led, relay}, 32'h0);
      $display("test service done");
      give_verdict();
   end
endmodule
`default_nettype wire
